//--- hw/asp_serial_protocol.sv
`timescale 1ns/10ps
// Functional notes
// - Bits launch on one serial clock edge, sampled on the opposite edge.
// - Source-synchronous strobe clock output; not selectable here, strobe held low.
// - Protocol field 0..3 sets idle clock level and capture edge.
// - After reset both directions use mode-0 protocol.
// - Protocol change written in mode 0, later frames use new protocol.
// - Write frames follow input protocol regardless of output protocol.
// - First result bit at chip-select fall for 0 and 2, first edge else.
// - Strobe output stays low through the whole clock-follower frame.
// - Output control zero and long frame: shifted-in bits pass to output.
// - Fewer than 20 clocks: input register unchanged, no command taken; the frame still reads and pops a result.
// - More than 20 clocks: last 20 bits form the command word.
// - Result loads into output register at next chip-select fall.
module asp_serial_protocol
(
    input  wire logic                   ref_clk,        // System clock, 100 MHz
    input  wire logic                   resetn,         // Async reset, active low
    input  wire logic                   sclk,           // Serial clock from host
    input  wire logic                   csN,            // Chip select, active low
    input  wire logic                   sdi,            // Serial data in
    output logic                        serialOutLanes, // Serial data out lane 0
    output logic                        serialOutOe,    // Lane driven
    output logic                        readyStrobeOut, // Strobe output
    input  wire logic [15:0]            resultData,     // Conversion result
    input  wire logic                   resultValid,    // Result strobe, one cycle
    output logic                        resultReady,    // Buffer can take result
    output logic [1:0]                  inputProtocolField,  // Active input protocol
    output logic [7:0]                  serialOutControlReg, // Output control value
    output logic [19:0]                 cmdWord,        // Last accepted command
    output logic                        cmdValid        // Command pulse, one cycle
);

    // Two-entry result buffer in the system domain
    logic [15:0]      bufMem [2];
    logic             wrPtr_ff, nxt_wrPtr, rdPtr_ff, nxt_rdPtr;
    logic [1:0]       cnt_ff, nxt_cnt;
    logic             bufPop;
    logic [15:0]      bufHead;

    // Crossing: frame end toggle and load toggle, both from the link into this domain
    logic             frameTgl_lk, loadTgl_lk;
    logic [2:0]       frameSync_ff, loadSync_ff;
    logic [2:0]       nxt_frameSync, nxt_loadSync;
    logic [19:0]      cmdHold_lk;
    logic [5:0]       cntHold_lk;

    logic [1:0]       proto_ff, nxt_proto;
    logic [7:0]       outCtrl_ff, nxt_outCtrl;
    logic [19:0]      cmd_ff, nxt_cmd;
    logic             cmdV_ff, nxt_cmdV;
    logic [15:0]      stage_ff, nxt_stage;
    asp_pkg::asp_state_t st_ff, nxt_st;

    assign resultReady = (cnt_ff != 2'h2);
    assign bufHead     = bufMem[rdPtr_ff];

    always_comb
    begin
        nxt_wrPtr = wrPtr_ff;
        nxt_rdPtr = rdPtr_ff;
        nxt_cnt   = cnt_ff;
        if (resultValid && resultReady)
        begin
            nxt_wrPtr = ~wrPtr_ff;
        end
        if (bufPop)
        begin
            nxt_rdPtr = ~rdPtr_ff;
        end
        nxt_cnt = cnt_ff + {1'b0, resultValid && resultReady} - {1'b0, bufPop};
    end

    always_ff @(posedge ref_clk)
    begin
        if (resultValid && resultReady)
        begin
            bufMem[wrPtr_ff] <= resultData;
        end
    end

    // Frame-end handling: decode command, commit protocol after frame
    always_comb
    begin
        nxt_frameSync = {frameSync_ff[1:0], frameTgl_lk};
        nxt_loadSync  = {loadSync_ff[1:0], loadTgl_lk};
        nxt_proto     = proto_ff;
        nxt_outCtrl   = outCtrl_ff;
        nxt_cmd       = cmd_ff;
        nxt_cmdV      = 1'b0;
        nxt_st        = st_ff;
        case (st_ff)
            asp_pkg::ASP_IDLE:
            begin
                if (frameSync_ff[2] != frameSync_ff[1])
                begin
                    nxt_st = asp_pkg::ASP_FRAME;
                end
            end
            asp_pkg::ASP_FRAME:
            begin
                if (cntHold_lk >= asp_pkg::CMD_MIN_CLKS)
                begin
                    nxt_cmd  = cmdHold_lk;
                    nxt_cmdV = 1'b1;
                    if (cmdHold_lk[asp_pkg::OPC_HI:asp_pkg::OPC_LO] == asp_pkg::OPC_WRITE)
                    begin
                        if (cmdHold_lk[asp_pkg::ADDR_HI:asp_pkg::ADDR_LO]
                            == asp_pkg::ADDR_IN_CTRL)
                        begin
                            nxt_proto = cmdHold_lk[1:0];
                        end
                        if (cmdHold_lk[asp_pkg::ADDR_HI:asp_pkg::ADDR_LO]
                            == asp_pkg::ADDR_OUT_CTRL)
                        begin
                            nxt_outCtrl = cmdHold_lk[7:0];
                        end
                    end
                end
                nxt_st = asp_pkg::ASP_DONE;
            end
            asp_pkg::ASP_DONE:
            begin
                nxt_st = asp_pkg::ASP_IDLE;
            end
            default:
            begin
                nxt_st = asp_pkg::ASP_IDLE;
            end
        endcase
    end

    // A load toggle from the link means the staged result was taken
    assign bufPop = (loadSync_ff[2] != loadSync_ff[1]) && (cnt_ff != 2'h0);

    // Stage mirrors the buffer head so the link side reads a flop, not the array
    always_comb
    begin
        nxt_stage = bufHead;
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wrPtr_ff     <= 1'b0;
            rdPtr_ff     <= 1'b0;
            cnt_ff       <= 2'h0;
            frameSync_ff <= 3'h0;
            loadSync_ff  <= 3'h0;
            proto_ff     <= asp_pkg::PROTO_RST;
            outCtrl_ff   <= asp_pkg::OUT_CTRL_RST;
            cmd_ff       <= 20'h00000;
            cmdV_ff      <= 1'b0;
            stage_ff     <= 16'h0000;
            st_ff        <= asp_pkg::ASP_IDLE;
        end
        else
        begin
            wrPtr_ff     <= nxt_wrPtr;
            rdPtr_ff     <= nxt_rdPtr;
            cnt_ff       <= nxt_cnt;
            frameSync_ff <= nxt_frameSync;
            loadSync_ff  <= nxt_loadSync;
            proto_ff     <= nxt_proto;
            outCtrl_ff   <= nxt_outCtrl;
            cmd_ff       <= nxt_cmd;
            cmdV_ff      <= nxt_cmdV;
            stage_ff     <= nxt_stage;
            st_ff        <= nxt_st;
        end
    end

    assign inputProtocolField  = proto_ff;
    assign serialOutControlReg = outCtrl_ff;
    assign cmdWord             = cmd_ff;
    assign cmdValid            = cmdV_ff;

    // Link domain. Protocol is stable within frames, since it changes only after
    // a frame end and the host spaces frames apart; stage is only sampled at chip-select fall.
    logic             capRise, launchFirstEdge;
    logic             capClk;
    logic [19:0]      shIn_lk;
    logic [19:0]      snap_lk;
    logic [5:0]       cnt_lk;
    logic [5:0]       outCnt_lk;
    logic [5:0]       outIdx;
    logic             outBit;
    logic             chain;

    assign capRise         = (proto_ff == asp_pkg::PROTO_00) || (proto_ff == asp_pkg::PROTO_11);
    assign launchFirstEdge = (proto_ff == asp_pkg::PROTO_01) || (proto_ff == asp_pkg::PROTO_11);
    assign chain           = (outCtrl_ff == asp_pkg::OUT_CTRL_CHAIN);
    // Capture clock: inverted for falling-edge protocols
    assign capClk          = capRise ? sclk : ~sclk;

    // Capture on the selected edge, count cleared at chip-select rise and held while deselected
    always_ff @(posedge capClk or posedge csN)
    begin
        if (csN)
        begin
            cnt_lk <= 6'h00;
        end
        else if (cnt_lk != asp_pkg::CNT_SAT)
        begin
            cnt_lk <= cnt_lk + 6'h01;
        end
    end

    always_ff @(posedge capClk)
    begin
        if (!csN)
        begin
            shIn_lk <= {shIn_lk[18:0], sdi};
        end
    end

    // Result is frozen at chip-select fall; the buffer pops only afterwards
    always_ff @(negedge csN)
    begin
        snap_lk <= {stage_ff, 4'h0};
    end

    // Launch edges counted on the edge opposite to capture
    always_ff @(negedge capClk or posedge csN)
    begin
        if (csN)
        begin
            outCnt_lk <= 6'h00;
        end
        else if (outCnt_lk != asp_pkg::CNT_SAT)
        begin
            outCnt_lk <= outCnt_lk + 6'h01;
        end
    end

    // Past the result word, with chaining on, the oldest of the last 20 input bits goes out; otherwise zero
    always_comb
    begin
        outIdx = launchFirstEdge ? (outCnt_lk - 6'h01) : outCnt_lk;
        outBit = 1'b0;
        if (launchFirstEdge && outCnt_lk == 6'h00)
        begin
            outBit = 1'b0;
        end
        else if (outIdx < 6'h14)
        begin
            outBit = snap_lk[5'h13 - outIdx[4:0]];
        end
        else if (chain)
        begin
            outBit = shIn_lk[19];
        end
    end

    // Frame end event: snapshot and toggle on chip-select rise
    always_ff @(posedge csN or negedge resetn)
    begin
        if (!resetn)
        begin
            frameTgl_lk <= 1'b0;
            cmdHold_lk  <= 20'h00000;
            cntHold_lk  <= 6'h00;
        end
        else
        begin
            frameTgl_lk <= ~frameTgl_lk;
            cmdHold_lk  <= shIn_lk;
            cntHold_lk  <= cnt_lk;
        end
    end

    // Chip-select fall consumes the staged result
    always_ff @(negedge csN or negedge resetn)
    begin
        if (!resetn)
        begin
            loadTgl_lk <= 1'b0;
        end
        else
        begin
            loadTgl_lk <= ~loadTgl_lk;
        end
    end

    // With first-edge launch the MSB appears after the first launch edge
    assign serialOutLanes = outBit;
    assign serialOutOe    = ~csN;
    assign readyStrobeOut = 1'b0;

    a_reset_proto: assert property (@(posedge ref_clk)
        $rose(resetn) |-> proto_ff == asp_pkg::PROTO_RST)
        else $error("protocol not default after reset");
    a_short_noop: assert property (@(posedge ref_clk) disable iff (!resetn)
        st_ff == asp_pkg::ASP_FRAME && cntHold_lk < asp_pkg::CMD_MIN_CLKS
        |=> !cmdV_ff && $stable(cmd_ff))
        else $error("short frame changed command");
    a_proto_commit: assert property (@(posedge ref_clk) disable iff (!resetn)
        $changed(proto_ff) |-> $past(st_ff) == asp_pkg::ASP_FRAME && cmdV_ff)
        else $error("protocol changed outside frame end");
    a_strobe_low: assert property (@(posedge ref_clk) disable iff (!resetn)
        !readyStrobeOut)
        else $error("strobe rose");

    sequence s_frameEnd;
        frameSync_ff[2] != frameSync_ff[1];
    endsequence
    sequence s_longFrame;
        st_ff == asp_pkg::ASP_FRAME && cntHold_lk >= asp_pkg::CMD_MIN_CLKS;
    endsequence

    a_frame_seen: assert property (@(posedge ref_clk) disable iff (!resetn)
        st_ff == asp_pkg::ASP_IDLE ##0 s_frameEnd |=> st_ff == asp_pkg::ASP_FRAME)
        else $error("frame end not taken");
    a_long_accept: assert property (@(posedge ref_clk) disable iff (!resetn)
        s_longFrame |=> cmdV_ff && cmd_ff == $past(cmdHold_lk))
        else $error("full frame not accepted");
    a_pop_count: assert property (@(posedge ref_clk) disable iff (!resetn)
        bufPop && !(resultValid && resultReady) |=> cnt_ff == $past(cnt_ff) - 2'h1)
        else $error("buffer pop lost");

endmodule // asp_serial_protocol

//--- hw/asp_pkg.sv
package asp_pkg;

    localparam int unsigned        CMD_BITS       = 20;
    localparam int unsigned        RESULT_BITS    = 20;
    localparam int unsigned        ADC_BITS       = 16;
    localparam int unsigned        CNT_W          = 6;
    localparam logic [CNT_W-1:0]   CMD_MIN_CLKS   = 6'h14;
    localparam logic [CNT_W-1:0]   CNT_SAT        = 6'h3F;

    localparam logic [1:0]         PROTO_RST      = 2'h0;
    localparam logic [7:0]         OUT_CTRL_RST   = 8'h00;
    localparam logic [7:0]         OUT_CTRL_CHAIN = 8'h00;

    // Command word: [19:16] opcode, [15:8] register address, [7:0] data
    localparam int unsigned        OPC_HI         = 19;
    localparam int unsigned        OPC_LO         = 16;
    localparam int unsigned        ADDR_HI        = 15;
    localparam int unsigned        ADDR_LO        = 8;
    localparam logic [3:0]         OPC_WRITE      = 4'h1;
    localparam logic [7:0]         ADDR_IN_CTRL   = 8'h10;
    localparam logic [7:0]         ADDR_OUT_CTRL  = 8'h14;

    // Protocol encodings of the input protocol field
    localparam logic [1:0]         PROTO_00       = 2'h0;
    localparam logic [1:0]         PROTO_01       = 2'h1;
    localparam logic [1:0]         PROTO_10       = 2'h2;
    localparam logic [1:0]         PROTO_11       = 2'h3;

    typedef enum logic [1:0] {
        ASP_IDLE  = 2'b00,
        ASP_FRAME = 2'b01,
        ASP_DONE  = 2'b11
    } asp_state_t;

endpackage

//--- verif/asp_host_model.sv
`timescale 1ns/10ps
module asp_host_model
(
    output logic      sclk, // Serial clock to device
    output logic      csN,  // Chip select, active low
    output logic      sdi,  // Serial data to device
    input  wire logic sdo   // Serial data from device
);
    initial
    begin
        sclk = 1'b0;
        csN  = 1'b1;
        sdi  = 1'b0;
    end

    // Clock toggles only inside frames; between them sclk is set to the idle level p[1] and sdi is inverted at release
    task automatic xfer(input logic [1:0] p, input int n, input logic [31:0] d,
                        output logic [31:0] q);
        logic [31:0] s;
        s    = d << (32 - n);
        q    = '0;
        sclk = p[1];
        sdi  = s[31];
        #6 csN = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            #6 sclk = ~sclk;
            if (p[0]) sdi = s[31];
            else q = {q[30:0], sdo};
            #6 sclk = ~sclk;
            if (p[0]) q = {q[30:0], sdo};
            else sdi = s[30];
            s = s << 1;
        end
        #6 csN = 1'b1;
        // Released line: show the inverse so a stale value is not mistaken
        sdi = ~sdi;
    endtask
endmodule // asp_host_model

//--- verif/asp_serial_protocol_tb.sv
`timescale 1ns/10ps
module asp_serial_protocol_tb;
    logic        refClk, resetN, sclk, csN, sdi, sdo, sdoOe, strobe;
    logic        resultReady, resultValid, cmdValid;
    logic [15:0] resultData, r, r2;
    logic [1:0]  protoField, cur;
    logic [7:0]  outCtrl;
    logic [19:0] cmdWord;
    logic [31:0] q, d;
    logic [19:0] cmdQ[$];
    int          nFail, testsRun, cycles;

    asp_serial_protocol dut (.ref_clk(refClk), .resetn(resetN), .sclk(sclk), .csN(csN),
        .sdi(sdi), .serialOutLanes(sdo), .serialOutOe(sdoOe), .readyStrobeOut(strobe),
        .resultData(resultData), .resultValid(resultValid), .resultReady(resultReady),
        .inputProtocolField(protoField), .serialOutControlReg(outCtrl),
        .cmdWord(cmdWord), .cmdValid(cmdValid));
    asp_host_model host (.sclk(sclk), .csN(csN), .sdi(sdi), .sdo(sdo));

    always #5 refClk = ~refClk;

    task check(input string nm, input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp)
        begin
            nFail++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task endOfTest;
        $display("checks %0d mismatches %0d", testsRun, nFail);
        if (nFail == 0 && testsRun > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task idle(input int n);
        repeat (n) @(posedge refClk);
    endtask

    task offer(input logic [15:0] v);
        int k;
        k = 0;
        do @(posedge refClk); while (resultReady !== 1'b1 && ++k < 50);
        resultData  <= v;
        resultValid <= 1'b1;
        @(posedge refClk);
        resultValid <= 1'b0;
    endtask

    task frame(input int n, input logic [31:0] dd);
        host.xfer(cur, n, dd, q);
        if (n >= 20) cmdQ.push_back(dd[19:0]);
        check("proto_hold", protoField, cur);
        idle(8);
    endtask

    function logic [19:0] wrIn(input logic [1:0] p);
        return {asp_pkg::OPC_WRITE, asp_pkg::ADDR_IN_CTRL, 6'h00, p};
    endfunction

    // Oldest expected command is matched against each accepted one
    always @(posedge refClk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            nFail++;
            endOfTest();
        end
        if (csN === 1'b0) check("strobe", strobe, 1'b0);
        if (cmdValid === 1'b1)
        begin
            if (cmdQ.size() == 0) check("cmd_extra", 1, 0);
            else check("cmd_word", cmdWord, cmdQ.pop_front());
        end
    end

    initial
    begin
        refClk = 1'b0;
        resetN = 1'b0;
        resultData = '0;
        resultValid = 1'b0;
        cur = asp_pkg::PROTO_00;
        nFail = 0;
        testsRun = 0;
        cycles = 0;
        r = 16'($urandom(32'hBDB7));
        idle(2);
        resetN <= 1'b1;
        idle(4);
        check("proto_rst", protoField, asp_pkg::PROTO_RST);
        check("outctl_rst", outCtrl, asp_pkg::OUT_CTRL_RST);
        frame(20, {asp_pkg::OPC_WRITE, asp_pkg::ADDR_OUT_CTRL, asp_pkg::OUT_CTRL_CHAIN});
        check("outctl", outCtrl, asp_pkg::OUT_CTRL_CHAIN);
        frame(19, wrIn(asp_pkg::PROTO_11));
        check("short_noop", protoField, cur);
        d = $urandom;
        d[19:0] = wrIn(asp_pkg::PROTO_00);
        frame(24, d);
        for (int i = 1; i < 5; i++)
        begin
            r = 16'($urandom);
            offer(r);
            idle(4);
            frame(20, 32'(wrIn(2'(i))));
            check("read_msb", q[19:4], r);
            cur = 2'(i);
            check("proto_new", protoField, cur);
        end
        r = 16'($urandom);
        offer(r);
        idle(4);
        d = $urandom;
        d[19:16] = 4'h0;
        frame(32, d);
        check("chain", q, {r, 4'h0, d[31:20]});
        r  = 16'($urandom);
        r2 = 16'($urandom);
        offer(r);
        offer(r2);
        idle(2);
        check("buf_full", resultReady, 1'b0);
        frame(16, $urandom);
        check("buf_first", q[15:0], r);
        frame(16, $urandom);
        check("buf_second", q[15:0], r2);
        check("buf_free", resultReady, 1'b1);
        check("cmd_left", cmdQ.size(), 0);
        endOfTest();
    end
endmodule // asp_serial_protocol_tb
